/* File: include/lfcmd_pkg.sv */
// shared constants of the lf command buffer and modulator sequencer
package lfcmd_pkg;

   // command buffer geometry
   localparam int FIFO_DEPTH      = 16;      // entries
   localparam int FIFO_AW         = 4;       // pointer width
   localparam int WORD_W          = 8;       // entry width
   localparam int LOW_LEVEL       = 4;       // a quarter of the depth

   // lf timing, counted in system clocks and lf periods
   localparam int LF_PERIOD_CLKS  = 64;      // system clocks per lf period
   localparam int DIV_W           = 6;
   localparam int SEL_DECAY_PER   = 32;      // periods with the old driver stopped
   localparam int SEL_SETTLE_PER  = 32;      // periods for the new driver to settle
   localparam int STD_BIT_PER     = 32;      // periods per bit, standard rate
   localparam int FAST_BIT_PER    = 22;      // periods per bit, fast rate
   localparam int MEAS_DELAY_PER  = 4;       // measurement starts in the 5th period
   localparam int GAP_PER         = 1;       // slot used by a current change
   localparam int PER_W           = 10;      // holds 31 x 32 periods
   localparam int ONP_W           = 6;

   // command byte layout: opcode in bits 7..5, argument in bits 4..0
   localparam int OP_LSB          = 5;
   localparam int OP_W            = 3;
   localparam int ARG_W           = 5;
   localparam logic [OP_W-1:0] OP_DATA = 3'h0;   // lf data header, arg = nibbles - 1
   localparam logic [OP_W-1:0] OP_SEL  = 3'h1;   // select driver
   localparam logic [OP_W-1:0] OP_CARR = 3'h4;   // carrier, arg = duration in bits
   localparam logic [OP_W-1:0] OP_CURR = 3'h5;   // coil current step
   localparam int SEL_BR_BIT      = 4;       // rate bit of select driver
   localparam int SEL_DM_BIT      = 3;       // diagnosis mode bit
   localparam int DRV_W           = 3;       // driver group and number
   localparam int CUR_W           = 5;

   // serial port reset configuration
   localparam logic CFG_POL_RST   = 1'b1;
   localparam logic CFG_PHA_RST   = 1'b1;

   // modulator states
   typedef enum logic [2:0] {
      LFCMD_IDLE   = 3'b000,
      LFCMD_DECAY  = 3'b001,
      LFCMD_SETTLE = 3'b010,
      LFCMD_DATA   = 3'b011,
      LFCMD_CARR   = 3'b100,
      LFCMD_GAP    = 3'b101
   } lfcmd_mod_e;

endpackage

/* File: core/lfcmd_modulator.sv */
// What this block does
// R1 - serial port resets to polarity 1, phase 1
// R2 - new serial setting applies at select falling edge
// R3 - data out driven only while select high
// R4 - trace outputs and interrupt follow operating mode
// R5 - buffer holds sixteen eight-bit command entries
// R6 - read and write pointers give fifo order
// R7 - buffer empty after wake-up from reset
// R8 - writes accepted while modulation is running
// R9 - interrupt on low fill and on overflow
// R10 - same-coil data and carrier joined without gaps
// R11 - entries executed one at a time in order
// R12 - driver select: 32 periods decay, 32 settle
// R13 - current change under one period, leaves gap
// R14 - data lasts nibbles times two times bitlength
// R15 - carrier lasts duration times bit length
// R16 - next command decoded during current one
// R17 - data bits on-off keyed onto the field
// R18 - standard 32 and fast 22 periods per bit
// R19 - shortest field interval 16 or 11 periods
// R20 - measurement from fifth period, off on zeros
// R21 - shortest data unit is four lf bits
// R22 - active marks transfer, bit change pulses data
// R23 - one lf period is 64 system clocks
// R24 - halt clears buffer, stops at period end
// R25 - speed status 0 standard, 1 fast
// R26 - write into full buffer dropped and latched
// R27 - low fill interrupt once per downward crossing
`timescale 1ns/10ps
module lfcmd_modulator
   import lfcmd_pkg::*;
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_srst,
   // serial pins and framer side
   input  wire logic              i_sel,          // serial select pin, high = selected
   input  wire logic              i_miso_bit,     // next output bit from the framer
   input  wire logic              i_cfg_wr,       // configuration command received
   input  wire logic              i_cfg_pol,
   input  wire logic              i_cfg_pha,
   output logic                   o_miso,
   output logic                   o_miso_oe,
   output logic                   o_serial_clock_polarity,
   output logic                   o_serial_clock_phase,
   // command stream from the framer
   input  wire logic              i_cmd_wr,       // one driver-related byte
   input  wire logic [WORD_W-1:0] i_cmd_byte,
   input  wire logic              i_start,        // start modulator operation
   input  wire logic              i_halt,         // halt command
   input  wire logic              i_status_rd,    // status read clears flags and irq
   input  wire logic              i_fault,        // driver fault level, other domain
   // status
   output logic                   o_irq,
   output logic                   o_buffer_low_flag,
   output logic                   o_buffer_overflow_flag,
   output logic                   o_reset_flag,
   output logic                   o_speed_fast,
   output logic [FIFO_AW:0]       o_fill_level,
   // driver side
   output logic                   o_field_on,
   output logic [DRV_W-1:0]       o_driver_sel,
   output logic                   o_diag_mode,
   output logic [CUR_W-1:0]       o_coil_current,
   output logic                   o_meas_en,
   // trace pins
   output logic                   o_modulation_active_out,
   output logic                   o_lf_bit_change_out
);

   // whole state of the block
   typedef struct packed {
      logic                                sel_m;     // select synchroniser
      logic                                sel_s;
      logic                                sel_d;     // for edge detection
      logic                                flt_m;     // fault synchroniser
      logic                                flt_s;
      logic                                serial_clock_polarity;
      logic                                serial_clock_phase;
      logic                                cfg_pend;
      logic                                pend_pol;
      logic                                pend_pha;
      logic                                miso;
      logic [FIFO_DEPTH-1:0][WORD_W-1:0]   mem;       // buffer entries
      logic [FIFO_AW-1:0]                  rd;
      logic [FIFO_AW-1:0]                  wr;
      logic [FIFO_AW:0]                    cnt;
      logic                                bu;
      logic                                bo;
      logic                                rst_flag;
      logic                                irq;
      lfcmd_mod_e                          st;
      logic                                run;
      logic                                halt_pend;
      logic                                fast;
      logic [DIV_W-1:0]                    div;       // clocks within a period
      logic [PER_W-1:0]                    per;       // periods left in this slot
      logic                                field;
      logic [ONP_W-1:0]                    on_per;    // periods since field came on
      logic                                bchg;
      logic [DRV_W-1:0]                    drv;
      logic [DRV_W-1:0]                    drv_pend;
      logic                                dm;
      logic                                dm_pend;
      logic [CUR_W-1:0]                    cur;
      logic [ARG_W:0]                      nib_left;
      logic [WORD_W-1:0]                   dbyte;
      logic                                hi;        // working on the upper nibble
      logic [1:0]                          bit_idx;   // gross bit within the nibble
   } lfcmd_state_s;

   lfcmd_state_s s_r;            // registered state
   lfcmd_state_s s_nxt;          // next state

   // next-state logic
   always_comb begin
      logic                   tick;
      logic [1:0]             npop;
      logic [WORD_W-1:0]      head;
      logic [OP_W-1:0]        op;
      logic [ARG_W-1:0]       arg;
      logic                   dispatch;
      logic                   push;
      logic [PER_W-1:0]       bitper;
      logic [PER_W-1:0]       halfper;
      logic [FIFO_AW:0]       cnt_new;
      tick     = (s_r.div == DIV_W'(LF_PERIOD_CLKS - 1));
      npop     = 2'h0;
      head     = s_r.mem[s_r.rd];
      op       = head[OP_LSB +: OP_W];
      arg      = head[ARG_W-1:0];
      dispatch = 1'b0;
      push     = 1'b0;
      bitper   = s_r.fast ? PER_W'(FAST_BIT_PER) : PER_W'(STD_BIT_PER);
      halfper  = bitper >> 1;
      cnt_new  = s_r.cnt;
      s_nxt    = s_r;
      s_nxt.bchg = 1'b0;

      // synchronisers: first stage read only by the second
      s_nxt.sel_m = i_sel;
      s_nxt.sel_s = s_r.sel_m;
      s_nxt.sel_d = s_r.sel_s;
      s_nxt.flt_m = i_fault;
      s_nxt.flt_s = s_r.flt_m;
      s_nxt.miso  = i_miso_bit;

      // R2 config held until select falls
      if (i_cfg_wr) begin
         s_nxt.cfg_pend = 1'b1;
         s_nxt.pend_pol = i_cfg_pol;
         s_nxt.pend_pha = i_cfg_pha;
      end
      if (s_r.sel_d && !s_r.sel_s && s_r.cfg_pend) begin
         s_nxt.serial_clock_polarity      = s_r.pend_pol;
         s_nxt.serial_clock_phase      = s_r.pend_pha;
         s_nxt.cfg_pend = i_cfg_wr;
      end

      // R23 lf period divider, free running
      s_nxt.div = tick ? '0 : s_r.div + DIV_W'(1);

      // R11 start request
      if (i_start) begin
         s_nxt.run = 1'b1;
      end

      if (tick) begin
         // R20 count field-on periods for measurement gating
         s_nxt.on_per = (s_r.field && s_r.on_per != '1) ? s_r.on_per + ONP_W'(1) : s_r.on_per;
         if (!s_r.field) begin
            s_nxt.on_per = '0;
         end
         // R24 halt or fault stops at the period end
         if (s_r.halt_pend || s_r.flt_s) begin
            s_nxt.st        = LFCMD_IDLE;
            s_nxt.run       = 1'b0;
            s_nxt.field     = 1'b0;
            s_nxt.halt_pend = 1'b0;
         end else begin
            case (s_r.st)
               LFCMD_IDLE: begin
                  dispatch = s_r.run;
               end
               // R12 decay, then switch, then settle
               LFCMD_DECAY: begin
                  if (s_r.per > PER_W'(1)) begin
                     s_nxt.per = s_r.per - PER_W'(1);
                  end else begin
                     s_nxt.drv = s_r.drv_pend;
                     s_nxt.dm  = s_r.dm_pend;
                     s_nxt.st  = LFCMD_SETTLE;
                     s_nxt.per = PER_W'(SEL_SETTLE_PER);
                  end
               end
               LFCMD_SETTLE, LFCMD_GAP, LFCMD_CARR: begin
                  if (s_r.per > PER_W'(1)) begin
                     s_nxt.per = s_r.per - PER_W'(1);
                  end else begin
                     dispatch = 1'b1;
                  end
               end
               LFCMD_DATA: begin
                  if (s_r.per > PER_W'(1)) begin
                     s_nxt.per = s_r.per - PER_W'(1);
                  end else if (s_r.bit_idx != 2'h3) begin
                     s_nxt.bit_idx = s_r.bit_idx + 2'h1;
                     s_nxt.per     = halfper;
                     s_nxt.bchg    = 1'b1;
                  end else if (s_r.nib_left == (ARG_W+1)'(1)) begin
                     dispatch = 1'b1;
                  end else begin
                     // next nibble: upper half, or a fresh data byte
                     s_nxt.nib_left = s_r.nib_left - (ARG_W+1)'(1);
                     s_nxt.bit_idx  = 2'h0;
                     s_nxt.per      = halfper;
                     s_nxt.bchg     = 1'b1;
                     if (!s_r.hi) begin
                        s_nxt.hi = 1'b1;
                     end else if (s_r.cnt != '0) begin
                        s_nxt.hi    = 1'b0;
                        s_nxt.dbyte = head;
                        npop        = 2'h1;
                     end else begin
                        // underrun: the telegram ends here
                        s_nxt.st    = LFCMD_IDLE;
                        s_nxt.run   = 1'b0;
                        s_nxt.bchg  = 1'b0;
                        s_nxt.field = 1'b0;
                     end
                  end
               end
               default: begin
                  s_nxt.st = LFCMD_IDLE;
               end
            endcase
         end
      end

      // R16 next entry decoded at the end of the current one
      if (dispatch) begin
         if (s_r.cnt == '0) begin
            s_nxt.st    = LFCMD_IDLE;
            s_nxt.run   = 1'b0;
            s_nxt.field = 1'b0;
         end else begin
            s_nxt.st  = LFCMD_GAP;
            s_nxt.per = PER_W'(GAP_PER);
            npop      = 2'h1;
            case (op)
               OP_SEL: begin
                  // R12 stop the driver for the decay time
                  s_nxt.st       = LFCMD_DECAY;
                  s_nxt.per      = PER_W'(SEL_DECAY_PER);
                  s_nxt.field    = 1'b0;
                  s_nxt.drv_pend = head[DRV_W-1:0];
                  s_nxt.dm_pend  = head[SEL_DM_BIT];
                  // R18 rate chosen with the driver
                  s_nxt.fast     = head[SEL_BR_BIT];
               end
               OP_CURR: begin
                  // R13 current switches now, slot leaves a gap
                  s_nxt.cur   = arg;
                  s_nxt.field = 1'b0;
               end
               OP_CARR: begin
                  // R15 carrier for arg bit times
                  if (arg != '0) begin
                     s_nxt.st    = LFCMD_CARR;
                     s_nxt.per   = PER_W'(arg * bitper);
                     s_nxt.field = 1'b1;
                  end else begin
                     s_nxt.field = 1'b0;
                  end
               end
               OP_DATA: begin
                  // R21 header needs its first data byte
                  if (s_r.cnt >= (FIFO_AW+1)'(2)) begin
                     // R14 each nibble is four gross bits of half a bit time
                     s_nxt.st       = LFCMD_DATA;
                     s_nxt.nib_left = (ARG_W+1)'(arg) + (ARG_W+1)'(1);
                     s_nxt.dbyte    = s_r.mem[s_r.rd + FIFO_AW'(1)];
                     s_nxt.hi       = 1'b0;
                     s_nxt.bit_idx  = 2'h0;
                     // R19 shortest field is one gross bit
                     s_nxt.per      = halfper;
                     s_nxt.bchg     = 1'b1;
                     npop           = 2'h2;
                  end else begin
                     // wait for the data byte; the field drops
                     npop        = 2'h0;
                     s_nxt.field = 1'b0;
                  end
               end
               default: begin
                  s_nxt.field = 1'b0;
               end
            endcase
         end
      end

      // R17 on-off keying from the current gross bit, low nibble first, msb first within each nibble
      if (s_nxt.st == LFCMD_DATA) begin
         s_nxt.field = s_nxt.hi ? s_nxt.dbyte[3'h7 - {1'b0, s_nxt.bit_idx}]
                                : s_nxt.dbyte[3'h3 - {1'b0, s_nxt.bit_idx}];
      end

      // R6 pop advances the read pointer
      s_nxt.rd = s_r.rd + FIFO_AW'(npop);
      cnt_new  = s_r.cnt - (FIFO_AW+1)'(npop);

      // status read clears flags first; events below set them again, so the set wins
      if (i_status_rd) begin
         s_nxt.bu       = 1'b0;
         s_nxt.bo       = 1'b0;
         s_nxt.irq      = 1'b0;
         s_nxt.rst_flag = 1'b0;
      end

      // R8 writes taken at any time, but lost with a halt in the same cycle; R26 full buffer drops them
      if (i_cmd_wr) begin
         if (cnt_new == (FIFO_AW+1)'(FIFO_DEPTH)) begin
            s_nxt.bo  = 1'b1;
            s_nxt.irq = 1'b1;
         end else begin
            push = 1'b1;
         end
      end
      if (push) begin
         // R5 one entry per command byte
         s_nxt.mem[s_r.wr] = i_cmd_byte;
         s_nxt.wr          = s_r.wr + FIFO_AW'(1);
         cnt_new           = cnt_new + (FIFO_AW+1)'(1);
      end

      // R24 halt bypasses and empties the buffer at once
      if (i_halt) begin
         s_nxt.rd        = '0;
         s_nxt.wr        = '0;
         cnt_new         = '0;
         s_nxt.halt_pend = 1'b1;
      end
      s_nxt.cnt = cnt_new;

      // R9 R27 low fill event on the downward crossing only
      if (s_r.cnt >= (FIFO_AW+1)'(LOW_LEVEL) && cnt_new < (FIFO_AW+1)'(LOW_LEVEL)) begin
         s_nxt.bu  = 1'b1;
         s_nxt.irq = 1'b1;
      end
   end

   // state register; R7 buffer empty after reset
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s_r          <= '0;
         // R1 default serial configuration
         s_r.serial_clock_polarity      <= CFG_POL_RST;
         s_r.serial_clock_phase      <= CFG_PHA_RST;
         s_r.pend_pol <= CFG_POL_RST;
         s_r.pend_pha <= CFG_PHA_RST;
         s_r.st       <= LFCMD_IDLE;
         s_r.rst_flag <= 1'b1;
         s_r.irq      <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // serial pin outputs
   assign o_serial_clock_polarity = s_r.serial_clock_polarity;
   assign o_serial_clock_phase    = s_r.serial_clock_phase;
   // R3 drive only while select is high
   assign o_miso_oe               = s_r.sel_s;
   assign o_miso                  = s_r.miso;

   // status outputs
   // R4 interrupt high during reset
   assign o_irq                   = s_r.irq || i_srst;
   assign o_buffer_low_flag       = s_r.bu;
   assign o_buffer_overflow_flag  = s_r.bo;
   assign o_reset_flag            = s_r.rst_flag;
   // R25 speed bit
   assign o_speed_fast            = s_r.fast;
   assign o_fill_level            = s_r.cnt;

   // driver outputs
   // R10 field stays on across joined commands
   assign o_field_on              = s_r.field;
   assign o_driver_sel            = s_r.drv;
   assign o_diag_mode             = s_r.dm;
   assign o_coil_current          = s_r.cur;
   // R20 measurement gated by on time
   assign o_meas_en               = s_r.field && (s_r.on_per >= ONP_W'(MEAS_DELAY_PER));

   // R4 R22 trace pins, low outside operation
   assign o_modulation_active_out = s_r.run;
   assign o_lf_bit_change_out     = s_r.bchg && s_r.run;

endmodule

/* File: tb/lfcmd_chk.sv */
`timescale 1ns/10ps
module lfcmd_chk
   import lfcmd_pkg::*;
(
   // watched inputs
   input  wire logic             i_clk,
   input  wire logic             i_srst,
   input  wire logic             i_sel,
   input  wire logic             i_miso_bit,
   input  wire logic             i_cmd_wr,
   input  wire logic             i_start,
   input  wire logic             i_halt,
   // watched outputs
   input  wire logic             o_miso,
   input  wire logic             o_miso_oe,
   input  wire logic             o_serial_clock_polarity,
   input  wire logic             o_serial_clock_phase,
   input  wire logic             o_irq,
   input  wire logic             o_buffer_overflow_flag,
   input  wire logic [FIFO_AW:0] o_fill_level,
   input  wire logic             o_field_on,
   input  wire logic             o_meas_en,
   input  wire logic             o_modulation_active_out,
   input  wire logic             o_lf_bit_change_out
);
   logic [15:0] on_cnt_r;         // unbroken field-on cycles

   // field run length
   always_ff @(posedge i_clk) begin
      if (i_srst || !o_field_on) begin
         on_cnt_r <= 16'h0000;
      end else begin
         on_cnt_r <= on_cnt_r + 16'h0001;
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);

   oe_off_a: assert property (!i_sel [*5] |-> !o_miso_oe)
      else $error("data pin driven while deselected");
   oe_on_a: assert property (i_sel [*5] |-> o_miso_oe && o_miso == $past(i_miso_bit))
      else $error("data pin not driven");
   irq_rst_a: assert property (disable iff (1'b0) i_srst |-> o_irq)
      else $error("irq low during reset");
   cfg_rst_a: assert property ($fell(i_srst) |-> o_serial_clock_polarity && o_serial_clock_phase)
      else $error("serial mode not default");
   cfg_hold_a: assert property (i_sel [*5] |=> $stable(o_serial_clock_polarity) && $stable(o_serial_clock_phase))
      else $error("serial mode changed while selected");
   fill_inc_a: assert property (i_cmd_wr && !i_halt && !i_start && !o_modulation_active_out && o_fill_level < 5'h10
      |=> o_fill_level == $past(o_fill_level) + 5'h01)
      else $error("fill level did not step by one");
   ovf_flag_a: assert property (i_cmd_wr && !i_halt && !o_modulation_active_out && o_fill_level == 5'h10
      |=> o_buffer_overflow_flag && o_irq && o_fill_level == 5'h10)
      else $error("overflow not latched");
   halt_clr_a: assert property (i_halt |=> o_fill_level == 5'h00)
      else $error("halt left entries behind");
   halt_stop_a: assert property (i_halt |-> ##[1:65] !o_field_on && !o_modulation_active_out)
      else $error("halt too slow");
   bit_chg_a: assert property (o_lf_bit_change_out |-> o_modulation_active_out ##1 !o_lf_bit_change_out)
      else $error("bad bit change pulse");
   meas_late_a: assert property (o_meas_en |-> o_field_on && on_cnt_r >= 16'h00c0)
      else $error("early measurement");
endmodule

bind lfcmd_modulator lfcmd_chk lfcmd_chk_inst (
   .i_clk(i_clk), .i_srst(i_srst), .i_sel(i_sel), .i_miso_bit(i_miso_bit), .i_cmd_wr(i_cmd_wr),
   .i_start(i_start), .i_halt(i_halt), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
   .o_serial_clock_polarity(o_serial_clock_polarity), .o_serial_clock_phase(o_serial_clock_phase),
   .o_irq(o_irq), .o_buffer_overflow_flag(o_buffer_overflow_flag), .o_fill_level(o_fill_level),
   .o_field_on(o_field_on), .o_meas_en(o_meas_en), .o_modulation_active_out(o_modulation_active_out),
   .o_lf_bit_change_out(o_lf_bit_change_out)
);

/* File: tb/lfcmd_mcu_mdl.sv */
`timescale 1ns/10ps
module lfcmd_mcu_mdl
   import lfcmd_pkg::*;
(
   // bench clock
   input  wire logic         i_clk,
   // framed words toward the device
   output logic              o_sel,
   output logic              o_cmd_wr,
   output logic [WORD_W-1:0] o_cmd_byte,
   output logic              o_cfg_wr,
   output logic              o_cfg_pol,
   output logic              o_cfg_pha
);
   // idle master
   initial begin
      o_sel = 1'b0;
      o_cmd_wr = 1'b0;
      o_cmd_byte = 8'h00;
      o_cfg_wr = 1'b0;
      o_cfg_pol = 1'b1;
      o_cfg_pha = 1'b1;
   end

   // one buffered word, byte inverted after
   task automatic send(input logic [WORD_W-1:0] b);
      @(negedge i_clk);
      o_cmd_wr = 1'b1;
      o_cmd_byte = b;
      @(negedge i_clk);
      o_cmd_wr = 1'b0;
      o_cmd_byte = ~b;
   endtask

   task automatic send_nibble(input logic [3:0] nib);
      send({OP_DATA, 5'h00});
      send({4'h0, nib});
   endtask

   // default mode use
   // framed in reset mode; select held until cfg_drop
   task automatic cfg_set(input logic serial_clock_polarity, input logic serial_clock_phase);
      @(negedge i_clk);
      o_sel = 1'b1;
      repeat (3) @(negedge i_clk);
      o_cfg_wr = 1'b1;
      o_cfg_pol = serial_clock_polarity;
      o_cfg_pha = serial_clock_phase;
      @(negedge i_clk);
      o_cfg_wr = 1'b0;
      o_cfg_pol = ~serial_clock_polarity;
      o_cfg_pha = ~serial_clock_phase;
      repeat (8) @(negedge i_clk);
   endtask

   // select falls, new setting applies
   task automatic cfg_drop();
      o_sel = 1'b0;
      repeat (8) @(negedge i_clk);
   endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top
   import lfcmd_pkg::*;
();
   logic i_clk, i_srst, i_start, i_halt, i_status_rd, i_fault, i_miso_bit;
   logic sel, cmd_wr, cfg_wr, serial_clock_polarity, serial_clock_phase, miso, oe, o_pol, o_pha, irq, low, ovf, rflag, fast;
   logic field, diag, meas, act, bchg;
   logic [WORD_W-1:0] cmd_byte;
   logic [FIFO_AW:0]  fill;
   logic [DRV_W-1:0]  drv;
   logic [CUR_W-1:0]  cur;
   int errors, checks, cyc;

   lfcmd_mcu_mdl lfcmd_mcu_mdl_inst (.i_clk(i_clk), .o_sel(sel), .o_cmd_wr(cmd_wr), .o_cmd_byte(cmd_byte),
      .o_cfg_wr(cfg_wr), .o_cfg_pol(serial_clock_polarity), .o_cfg_pha(serial_clock_phase));
   lfcmd_modulator lfcmd_modulator_inst (.i_clk(i_clk), .i_srst(i_srst), .i_sel(sel), .i_miso_bit(i_miso_bit),
      .i_cfg_wr(cfg_wr), .i_cfg_pol(serial_clock_polarity), .i_cfg_pha(serial_clock_phase), .o_miso(miso), .o_miso_oe(oe),
      .o_serial_clock_polarity(o_pol), .o_serial_clock_phase(o_pha), .i_cmd_wr(cmd_wr), .i_cmd_byte(cmd_byte),
      .i_start(i_start), .i_halt(i_halt), .i_status_rd(i_status_rd), .i_fault(i_fault), .o_irq(irq),
      .o_buffer_low_flag(low), .o_buffer_overflow_flag(ovf), .o_reset_flag(rflag), .o_speed_fast(fast),
      .o_fill_level(fill), .o_field_on(field), .o_driver_sel(drv), .o_diag_mode(diag), .o_coil_current(cur),
      .o_meas_en(meas), .o_modulation_active_out(act), .o_lf_bit_change_out(bchg));

   // clock, 40 ns period
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // fresh framer bit each cycle
   always @(negedge i_clk) i_miso_bit <= 1'($urandom);

   // hang guard, tests need ~25k cycles
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         finish_test();
      end
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic pulse(ref logic s);
      @(negedge i_clk);
      s = 1'b1;
      @(negedge i_clk);
      s = 1'b0;
   endtask

   // field-on cycles: two carrier bits, two half data bits
   function automatic int exp_on(input int bp);
      return 3 * bp * LF_PERIOD_CLKS;
   endfunction

   // carrier joins first data one
   function automatic int exp_run(input int bp);
      return (2 * bp + bp / 2) * LF_PERIOD_CLKS;
   endfunction

   task automatic finish_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      int bp, on, run, mx, bc, n, first;
      logic [2:0] d;
      logic [4:0] c;
      void'($urandom(32'h82726e61));
      {i_srst, i_start, i_halt, i_status_rd, i_fault} = 5'h10;
      repeat (4) @(negedge i_clk);
      chk("irq_rst", 1, irq);
      i_srst = 1'b0;
      @(negedge i_clk);
      chk("fill_rst", 0, fill);
      chk("cfg_rst", 3, {o_pol, o_pha});
      chk("speed_rst", 0, fast);
      chk("act_rst", 0, {act, bchg});
      chk("rflag_rst", 1, rflag);
      // new mode waits for select fall
      lfcmd_mcu_mdl_inst.cfg_set(1'b0, 1'b0);
      chk("cfg_held", 3, {o_pol, o_pha});
      lfcmd_mcu_mdl_inst.cfg_drop();
      chk("cfg_new", 0, {o_pol, o_pha});
      chk("oe_idle", 0, oe);
      pulse(i_status_rd);
      chk("irq_clr", 0, irq);
      chk("rflag_clr", 0, rflag);
      // fill with random words, then overflow
      repeat (16) lfcmd_mcu_mdl_inst.send(8'($urandom));
      chk("fill_full", 16, fill);
      lfcmd_mcu_mdl_inst.send(8'($urandom));
      chk("fill_ovf", 16, fill);
      chk("ovf_irq", 3, {ovf, irq});
      pulse(i_halt);
      chk("fill_halt", 0, fill);
      // per rate: select, current, carrier, nibble 1010
      for (int r = 0; r < 2; r++) begin
         bp = r ? FAST_BIT_PER : STD_BIT_PER;
         d = 3'($urandom);
         c = 5'($urandom);
         lfcmd_mcu_mdl_inst.send({OP_SEL, r[0], 1'b0, d});
         lfcmd_mcu_mdl_inst.send({OP_CURR, c});
         lfcmd_mcu_mdl_inst.send({OP_CARR, 5'h02});
         lfcmd_mcu_mdl_inst.send_nibble(4'ha);
         pulse(i_status_rd);
         chk("low_pre", 0, low);
         pulse(i_start);
         {on, run, mx, bc, n, first} = '0;
         while (act === 1'b1 && n < 30000) begin
            @(negedge i_clk);
            n++;
            run = field ? run + 1 : 0;
            on += field;
            bc += bchg;
            if (field && first == 0) first = n;
            if (run > mx) mx = run;
         end
         chk("sel_wait", 1, first >= 65 * 64 && first <= 66 * 64 + 2);
         chk("on_time", exp_on(bp), on);
         chk("seamless", exp_run(bp), mx);
         chk("bit_chg", 4, bc);
         chk("setup", {d, c}, {drv, cur});
         chk("speed", r, fast);
         chk("diag", 0, diag);
         chk("low_irq", 3, {low, irq});
         chk("drained", 0, fill);
      end
      // long carrier, write during run, halt
      lfcmd_mcu_mdl_inst.send({OP_CARR, 5'h1f});
      pulse(i_start);
      repeat (3000) @(negedge i_clk);
      lfcmd_mcu_mdl_inst.send(8'ha3);
      chk("fill_run", 1, fill);
      pulse(i_halt);
      repeat (66) @(negedge i_clk);
      chk("halt_stop", 0, {field, act, fill});
      finish_test();
   end
endmodule
